// ==== verilog/glt_pkg.sv ====
// Purpose: Shared constants and types of the guard lock teach control.
// Assumes: One 125 MHz clock; all timing counts derive from it.
// Notes: Times are kept in their own unit with derived ms tick counts.
package glt_pkg;

    localparam int unsigned CLK_HZ = 125_000_000;
    // Base tick of 1 ms drives all slow timers.
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // Blink half periods, in ms ticks.
    localparam int unsigned BLINK_1HZ_MS = 500;
    localparam int unsigned BLINK_3HZ_MS = 167;
    // Teach timing.
    localparam int unsigned TEACH_WAIT_S = 10;
    localparam int unsigned TEACH_WAIT_MS = TEACH_WAIT_S * 1000;
    localparam int unsigned POWER_OFF_MIN = 5;
    localparam int unsigned POWER_OFF_MS = POWER_OFF_MIN * 60 * 1000;
    localparam int unsigned INHIBIT_MIN = 10;
    localparam int unsigned INHIBIT_MS = INHIBIT_MIN * 60 * 1000;
    localparam int unsigned FAULT_FLASHES = 5;
    localparam int unsigned FLASH_GAP_MS = 2000;
    localparam logic [2:0] FLASH_CNT_RESET = 3'h0;
    localparam logic [9:0] BLINK_CNT_RESET = 10'h000;

    // Teach sequencer states, one-hot.
    typedef enum logic [6:0] {
        GLT_IDLE = 7'h01,
        GLT_TEACH = 7'h02,
        GLT_POWREQ = 7'h04,
        GLT_ABORT = 7'h08,
        GLT_CONFIRM = 7'h10,
        GLT_INHIBIT = 7'h20,
        GLT_RUN = 7'h40
    } glt_state_t;

endpackage

// ==== verilog/glt_tick_if.sv ====
`timescale 1ns/1ps
// Purpose: Carries the slow timing strobes from the divider to the core.
// Assumes: tick_ms is a one-cycle pulse, the blink signals are levels, all in the ref_clk domain.
// Notes: The divider drives, the core listens.
interface glt_tick_if;
    logic tick_ms;
    logic blink_slow;
    logic blink_fast;
    modport src (output tick_ms, output blink_slow, output blink_fast);
    modport dst (input tick_ms, input blink_slow, input blink_fast);
endinterface

// ==== verilog/glt_tick_gen.sv ====
`timescale 1ns/1ps
// Purpose: Prescaler giving a 1 ms tick and 1 Hz and 3 Hz blink levels.
// Assumes: ref_clk at 125 MHz.
// Notes: Blink outputs are square-wave levels, not pulses.
module glt_tick_gen
    import glt_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Timing strobes.
    glt_tick_if.src ticks
);

    typedef struct packed {
        logic [16:0] pre;
        logic [9:0] slow_cnt;
        logic [9:0] fast_cnt;
        logic tick;
        logic slow;
        logic fast;
    } glt_tick_t;

    glt_tick_t st_reg;
    glt_tick_t st_next;

    // Divide down to ms ticks, then to the blink half periods.
    always_comb begin
        st_next = st_reg;
        st_next.tick = 1'b0;
        if (st_reg.pre == 17'(TICK_DIV - 1)) begin
            st_next.pre = 17'h00000;
            st_next.tick = 1'b1;
        end else begin
            st_next.pre = st_reg.pre + 17'h00001;
        end
        if (st_reg.tick) begin
            if (st_reg.slow_cnt == 10'(BLINK_1HZ_MS - 1)) begin
                st_next.slow_cnt = BLINK_CNT_RESET;
                st_next.slow = ~st_reg.slow;
            end else begin
                st_next.slow_cnt = st_reg.slow_cnt + 10'h001;
            end
            if (st_reg.fast_cnt == 10'(BLINK_3HZ_MS - 1)) begin
                st_next.fast_cnt = BLINK_CNT_RESET;
                st_next.fast = ~st_reg.fast;
            end else begin
                st_next.fast_cnt = st_reg.fast_cnt + 10'h001;
            end
        end
    end

    // All counters clear on power-up.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ticks.tick_ms = st_reg.tick;
    assign ticks.blink_slow = st_reg.slow;
    assign ticks.blink_fast = st_reg.fast;

endmodule

// ==== verilog/glt_flash_gen.sv ====
`timescale 1ns/1ps
// Purpose: Repeating burst of red flashes for the teach-in abort code.
// Assumes: Timing strobes from the prescaler.
// Notes: Bursts repeat with a pause while enabled.
module glt_flash_gen
    import glt_pkg::*;
(
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Timing and control.
    glt_tick_if.dst ticks,
    input wire logic enable,
    // Output level.
    output logic flash
);

    typedef struct packed {
        logic [2:0] count;
        logic [11:0] gap;
        logic prev;
        logic out;
    } glt_flash_t;

    glt_flash_t st_reg;
    glt_flash_t st_next;

    // Count rising edges of the slow blink; pause after each burst.
    always_comb begin
        st_next = st_reg;
        st_next.prev = ticks.blink_slow;
        if (!enable) begin
            st_next.count = FLASH_CNT_RESET;
            st_next.gap = 12'h000;
            st_next.out = 1'b0;
        end else if (st_reg.gap != 12'h000) begin
            st_next.out = 1'b0;
            if (ticks.tick_ms) begin
                st_next.gap = st_reg.gap - 12'h001;
            end
        end else begin
            // The pause starts on the fall of the last flash, so that no
            // flash is cut short; a phase caught mid-way stays dark.
            if (ticks.blink_slow && !st_reg.prev) begin
                st_next.count = st_reg.count + 3'h1;
            end else if (!ticks.blink_slow && st_reg.prev &&
                    st_reg.count == 3'(FAULT_FLASHES)) begin
                st_next.count = FLASH_CNT_RESET;
                st_next.gap = 12'(FLASH_GAP_MS);
            end
            st_next.out = ticks.blink_slow &&
                (st_next.count != FLASH_CNT_RESET);
        end
    end

    // State register.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign flash = st_reg.out;

endmodule

// ==== verilog/glt_core.sv ====
`timescale 1ns/1ps
// Purpose: Teach-in sequencer, lock command, safety outputs and LEDs.
// Assumes: reset_n is the power-up reset; inputs synchronous to ref_clk.
// Notes: The learned code is held in a nonvolatile cell outside.
// Function
// - Teach-in start after power cycle: green off, red on, yellow 1 Hz.
// - After ten seconds yellow blinks at 3 Hz asking power removal.
// - No power-off in five minutes: abort, five red flashes.
// - After power return, new detection activates and stores the code.
// - One-time variant: pairing permanent, later teach-in refused.
// - Repeat variant: teach-in unlimited, new code voids the old.
// - After learning, outputs inhibited for ten minutes.
// - Green blinks until inhibit expired and new actuator detected.
// - Power loss during inhibit restarts the full ten minutes.
// - No locking while the selector sits between positions.
// - Power-to-unlock: high control input unlocks, else locked.
// - Power-to-lock: high control input locks, else released.
// - Lock-monitor variant: unlock drops outputs, relock restores them.
// - Door-monitor variant: only opening the guard drops outputs.
// - Green shows supply, yellow operating state, red faults.
// - Missing safety input: green 1 Hz, red off, yellow per guard.
module glt_core
    import glt_pkg::*;
#(
    parameter int unsigned TEACH_WAIT_TICKS = TEACH_WAIT_MS,
    parameter int unsigned POWER_OFF_TICKS = POWER_OFF_MS,
    parameter int unsigned INHIBIT_TICKS = INHIBIT_MS,
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    // Clock and power-up reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Variant straps.
    input wire logic one_time_teach_variant,
    input wire logic repeat_teach_variant,
    input wire logic power_to_lock_variant,
    input wire logic door_monitor_variant,
    // Machine side.
    input wire logic solenoid_ctrl,
    input wire logic safety_in_a,
    input wire logic safety_in_b,
    // Sensor side.
    input wire logic actuator_present,
    input wire logic actuator_new,
    input wire logic guard_closed,
    input wire logic bolt_engaged,
    input wire logic selector_pos_one,
    input wire logic selector_pos_two,
    // Nonvolatile teach record.
    input wire logic nv_code_taught,
    input wire logic nv_pending,
    input wire logic nv_inhibit,
    output logic nv_set_pending,
    output logic nv_commit,
    output logic nv_inhibit_done,
    // Actuation and outputs.
    output logic solenoid_lock,
    output logic safety_out_a,
    output logic safety_out_b,
    output logic led_green,
    output logic led_yellow,
    output logic led_red
);

    glt_tick_if ticks ();
    logic flash_red;

    typedef struct packed {
        glt_state_t state;
        logic [19:0] timer;
        logic started;
        logic set_pending;
        logic commit;
        logic inhibit_done;
        logic lock;
        logic out_en;
        logic green;
        logic yellow;
        logic red;
    } glt_core_t;

    glt_core_t st_reg;
    glt_core_t st_next;

    logic teach_allowed;
    logic lock_cmd;
    logic chain_ok;

    glt_tick_gen #(.TICK_DIV(TICK_DIV)) u_tick (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .ticks(ticks)
    );

    glt_flash_gen u_flash (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .ticks(ticks),
        .enable(st_reg.state == GLT_ABORT),
        .flash(flash_red)
    );

    // Teach permission depends on the variant and on a stored pairing.
    always_comb begin
        teach_allowed = 1'b0;
        if (repeat_teach_variant) begin
            teach_allowed = 1'b1;
        end else if (one_time_teach_variant) begin
            teach_allowed = !nv_code_taught;
        end
    end

    // Solenoid command polarity, refused with the selector in between.
    always_comb begin
        if (power_to_lock_variant) begin
            lock_cmd = solenoid_ctrl;
        end else begin
            lock_cmd = !solenoid_ctrl;
        end
        if (!(selector_pos_one || selector_pos_two)) begin
            lock_cmd = 1'b0;
        end
    end

    assign chain_ok = safety_in_a && safety_in_b;

    // Sequencer, output enabling and indicator selection.
    always_comb begin
        st_next = st_reg;
        st_next.set_pending = 1'b0;
        st_next.commit = 1'b0;
        st_next.inhibit_done = 1'b0;
        st_next.lock = lock_cmd && guard_closed;
        if (ticks.tick_ms && st_reg.timer != 20'h00000) begin
            st_next.timer = st_reg.timer - 20'h00001;
        end
        case (st_reg.state)
            GLT_IDLE: begin
                st_next.started = 1'b1;
                if (nv_pending && actuator_new) begin
                    st_next.state = GLT_CONFIRM;
                end else if (nv_inhibit) begin
                    // Restart the whole inhibit after any power loss.
                    st_next.state = GLT_INHIBIT;
                    st_next.started = 1'b0;
                    st_next.timer = 20'(INHIBIT_TICKS);
                end else if (actuator_new && teach_allowed) begin
                    st_next.state = GLT_TEACH;
                    st_next.timer = 20'(TEACH_WAIT_TICKS);
                end else if (!nv_pending) begin
                    st_next.state = GLT_RUN;
                end
            end
            GLT_TEACH: begin
                if (st_reg.timer == 20'h00000) begin
                    st_next.state = GLT_POWREQ;
                    st_next.set_pending = 1'b1;
                    st_next.timer = 20'(POWER_OFF_TICKS);
                end
            end
            GLT_POWREQ: begin
                if (st_reg.timer == 20'h00000) begin
                    st_next.state = GLT_ABORT;
                end
            end
            GLT_ABORT: begin
                st_next.state = GLT_ABORT;
            end
            GLT_CONFIRM: begin
                // Commit replaces any earlier code, then inhibit runs.
                st_next.commit = 1'b1;
                st_next.started = 1'b0;
                st_next.state = GLT_INHIBIT;
                st_next.timer = 20'(INHIBIT_TICKS);
            end
            GLT_INHIBIT: begin
                if (st_reg.timer == 20'h00000) begin
                    st_next.inhibit_done = 1'b1;
                    st_next.state = GLT_RUN;
                end
            end
            GLT_RUN: begin
                if (actuator_new && teach_allowed && !actuator_present) begin
                    st_next.state = GLT_RUN;
                end
            end
            default: begin
                st_next.state = GLT_IDLE;
            end
        endcase

        // Output enabling per variant; inhibit and teach hold them off.
        st_next.out_en = 1'b0;
        if (st_reg.state == GLT_RUN && chain_ok && actuator_present &&
                guard_closed) begin
            if (door_monitor_variant) begin
                st_next.out_en = 1'b1;
            end else begin
                st_next.out_en = bolt_engaged;
            end
        end
        if (st_reg.state == GLT_INHIBIT) begin
            st_next.out_en = 1'b0;
        end

        // Indicators: supply, operating state, fault.
        st_next.green = 1'b1;
        st_next.red = 1'b0;
        if (!guard_closed) begin
            st_next.yellow = 1'b0;
        end else if (bolt_engaged) begin
            st_next.yellow = 1'b1;
        end else begin
            st_next.yellow = ticks.blink_slow;
        end
        case (st_reg.state)
            GLT_TEACH: begin
                st_next.green = 1'b0;
                st_next.red = 1'b1;
                st_next.yellow = ticks.blink_slow;
            end
            GLT_POWREQ: begin
                st_next.green = 1'b0;
                st_next.red = 1'b1;
                st_next.yellow = ticks.blink_fast;
            end
            GLT_ABORT: begin
                st_next.green = 1'b1;
                st_next.yellow = 1'b0;
                st_next.red = flash_red;
            end
            GLT_CONFIRM, GLT_INHIBIT: begin
                st_next.green = ticks.blink_slow;
                st_next.yellow = 1'b0;
            end
            default: begin
                if (!chain_ok) begin
                    st_next.green = ticks.blink_slow;
                    st_next.red = 1'b0;
                end
            end
        endcase
        // Green keeps blinking until the new actuator is seen again.
        if (st_reg.state == GLT_RUN && !st_reg.started) begin
            st_next.green = ticks.blink_slow;
        end
        // Any sighting after learning counts, even one during the inhibit.
        if (st_reg.state != GLT_IDLE && actuator_present) begin
            st_next.started = 1'b1;
        end
    end

    // State register; power-up loads GLT_IDLE and clears the rest.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= '{state: GLT_IDLE, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    assign nv_set_pending = st_reg.set_pending;
    assign nv_commit = st_reg.commit;
    assign nv_inhibit_done = st_reg.inhibit_done;
    assign solenoid_lock = st_reg.lock;
    assign safety_out_a = st_reg.out_en;
    assign safety_out_b = st_reg.out_en;
    assign led_green = st_reg.green;
    assign led_yellow = st_reg.yellow;
    assign led_red = st_reg.red;

endmodule

// ==== verif/glt_core_asserts.sv ====
// Purpose: Concurrent checks on the ports of the guard lock core.
// Assumes: Outputs register one cycle after the inputs they follow.
// Notes: Timer counts are passed on but the checks need none of them.
`timescale 1ns/1ps
module glt_core_asserts
    import glt_pkg::*;
#(
    parameter int unsigned TEACH_WAIT_TICKS = TEACH_WAIT_MS,
    parameter int unsigned POWER_OFF_TICKS = POWER_OFF_MS,
    parameter int unsigned INHIBIT_TICKS = INHIBIT_MS
) (
    // Clock and reset.
    input wire logic ref_clk,
    input wire logic reset_n,
    // Straps and machine inputs.
    input wire logic power_to_lock_variant,
    input wire logic door_monitor_variant,
    input wire logic solenoid_ctrl,
    input wire logic safety_in_a,
    input wire logic safety_in_b,
    // Sensor and teach record inputs.
    input wire logic guard_closed,
    input wire logic bolt_engaged,
    input wire logic selector_pos_one,
    input wire logic selector_pos_two,
    input wire logic nv_pending,
    // Watched outputs.
    input wire logic nv_commit,
    input wire logic nv_inhibit_done,
    input wire logic solenoid_lock,
    input wire logic safety_out_a,
    input wire logic safety_out_b
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    // Outputs stay off and the inhibit keeps running for eight cycles after a commit.
    sequence s_quiet;
        (!safety_out_a && !nv_inhibit_done) [*8];
    endsequence

    a_outs_chain_ok: assert property (safety_out_a |->
        $past(safety_in_a && safety_in_b)) else $error("outputs without chain");
    a_outs_guard_closed: assert property (safety_out_a |->
        $past(guard_closed)) else $error("outputs with guard open");
    a_lock_mon_bolt: assert property (
        (safety_out_a && !door_monitor_variant) |-> $past(bolt_engaged))
        else $error("outputs while unlocked");
    a_outs_both_same: assert property (
        safety_out_a == safety_out_b) else $error("output channels differ");
    a_lock_sel_valid: assert property (solenoid_lock |->
        $past(selector_pos_one || selector_pos_two))
        else $error("lock with selector between positions");
    a_lock_cmd_pol: assert property (solenoid_lock |->
        $past(power_to_lock_variant ? solenoid_ctrl : !solenoid_ctrl))
        else $error("lock against control level");
    a_unlock_cmd_pol: assert property (
        $past(power_to_lock_variant ? !solenoid_ctrl : solenoid_ctrl)
        |-> !solenoid_lock) else $error("no release on control level");
    a_commit_one_shot: assert property (nv_commit |=> !nv_commit)
        else $error("commit longer than one cycle");
    a_commit_needs_pend: assert property (nv_commit |->
        $past(nv_pending)) else $error("commit without pending code");
    a_commit_quiet: assert property (nv_commit |=> s_quiet)
        else $error("outputs during inhibit");
endmodule

bind glt_core glt_core_asserts #(.TEACH_WAIT_TICKS(TEACH_WAIT_TICKS),
    .POWER_OFF_TICKS(POWER_OFF_TICKS), .INHIBIT_TICKS(INHIBIT_TICKS))
    i_glt_core_asserts (.ref_clk(ref_clk), .reset_n(reset_n),
    .power_to_lock_variant(power_to_lock_variant),
    .door_monitor_variant(door_monitor_variant),
    .solenoid_ctrl(solenoid_ctrl), .safety_in_a(safety_in_a),
    .safety_in_b(safety_in_b), .guard_closed(guard_closed),
    .bolt_engaged(bolt_engaged), .selector_pos_one(selector_pos_one),
    .selector_pos_two(selector_pos_two), .nv_pending(nv_pending),
    .nv_commit(nv_commit), .nv_inhibit_done(nv_inhibit_done),
    .solenoid_lock(solenoid_lock), .safety_out_a(safety_out_a),
    .safety_out_b(safety_out_b));

// ==== verif/glt_machine_model.sv ====
// Purpose: Machine solenoid control and two-channel safety monitor.
// Assumes: The strap tells which control level means lock.
// Notes: The monitor releases the machine only with both channels on.
`timescale 1ns/1ps
module glt_machine_model (
    // Clock.
    input wire logic ref_clk,
    // Lock request and variant strap.
    input wire logic want_lock,
    input wire logic power_to_lock_variant,
    // Toward the device.
    output logic solenoid_ctrl = 1'b0,
    // Safety outputs and monitor verdict.
    input wire logic safety_out_a,
    input wire logic safety_out_b,
    output logic guard_released = 1'b0
);
    // Control level follows the variant polarity; monitor needs both.
    always @(posedge ref_clk) begin
        solenoid_ctrl <= want_lock ~^ power_to_lock_variant;
        guard_released <= safety_out_a & safety_out_b;
    end
endmodule

// ==== verif/glt_core_bench.sv ====
// Purpose: Self-checking bench of the guard lock core.
// Assumes: A tick of four cycles lets every timer but the flash pause run out in the run.
// Notes: Each scenario power-cycles the core before it starts.
`timescale 1ns/1ps
module glt_core_bench;
    import glt_pkg::*;
    logic ref_clk = 1'b0, reset_n = 1'b0, want_lock = 1'b0;
    logic one_time_teach_variant = 1'b0, repeat_teach_variant = 1'b0;
    logic power_to_lock_variant = 1'b0, door_monitor_variant = 1'b0;
    logic safety_in_a = 1'b0, safety_in_b = 1'b0, guard_closed = 1'b0;
    logic actuator_present = 1'b0, actuator_new = 1'b0, bolt_engaged = 1'b0;
    logic selector_pos_one = 1'b0, selector_pos_two = 1'b0;
    logic nv_code_taught = 1'b0, nv_pending = 1'b0, nv_inhibit = 1'b0;
    logic solenoid_ctrl, guard_released, nv_set_pending, nv_commit;
    logic nv_inhibit_done, solenoid_lock, safety_out_a, safety_out_b;
    logic led_green, led_yellow, led_red;
    int err_count = 0;
    int n_compared = 0;
    int cyc = 0;
    // Clock cycles per millisecond tick in this bench.
    localparam int TICK = 4;
    localparam int CYCLE_LIMIT = 40000;

    glt_core #(.TEACH_WAIT_TICKS(5), .POWER_OFF_TICKS(10),
        .INHIBIT_TICKS(20), .TICK_DIV(TICK)) i_glt_core (.ref_clk(ref_clk),
        .reset_n(reset_n),
        .one_time_teach_variant(one_time_teach_variant),
        .repeat_teach_variant(repeat_teach_variant),
        .power_to_lock_variant(power_to_lock_variant),
        .door_monitor_variant(door_monitor_variant),
        .solenoid_ctrl(solenoid_ctrl), .safety_in_a(safety_in_a),
        .safety_in_b(safety_in_b), .actuator_present(actuator_present),
        .actuator_new(actuator_new), .guard_closed(guard_closed),
        .bolt_engaged(bolt_engaged), .selector_pos_one(selector_pos_one),
        .selector_pos_two(selector_pos_two), .nv_code_taught(nv_code_taught),
        .nv_pending(nv_pending), .nv_inhibit(nv_inhibit),
        .nv_set_pending(nv_set_pending), .nv_commit(nv_commit),
        .nv_inhibit_done(nv_inhibit_done), .solenoid_lock(solenoid_lock),
        .safety_out_a(safety_out_a), .safety_out_b(safety_out_b),
        .led_green(led_green), .led_yellow(led_yellow), .led_red(led_red));

    glt_machine_model i_glt_machine_model (.ref_clk(ref_clk),
        .want_lock(want_lock), .power_to_lock_variant(power_to_lock_variant),
        .solenoid_ctrl(solenoid_ctrl), .safety_out_a(safety_out_a),
        .safety_out_b(safety_out_b), .guard_released(guard_released));

    // Clock of 8 ns period.
    always #4 ref_clk = ~ref_clk;

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Cuts a hung run short.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == CYCLE_LIMIT) begin
            err_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // Normal running set-up: chain closed, guard shut, known actuator.
    task automatic base;
        {one_time_teach_variant, power_to_lock_variant} <= 2'h0;
        {door_monitor_variant, want_lock, actuator_new} <= 3'h0;
        {nv_pending, nv_inhibit, selector_pos_two} <= 3'h0;
        {repeat_teach_variant, safety_in_a, safety_in_b} <= 3'h7;
        {guard_closed, actuator_present, bolt_engaged} <= 3'h7;
        {selector_pos_one, nv_code_taught} <= 2'h3;
    endtask

    task automatic pwr_cycle;
        reset_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic watch(input int n, output int c, output int o, output int d);
        {c, o, d} = {32'h0, 32'h0, 32'h0};
        repeat (n) begin
            @(negedge ref_clk);
            c += (nv_commit === 1'b1);
            o += (safety_out_a !== 1'b0 || safety_out_b !== 1'b0);
            d += (nv_inhibit_done === 1'b1);
        end
    endtask

    task automatic s_chain;
        @(posedge ref_clk);
        base();
        want_lock <= 1'b1;
        pwr_cycle();
        settle(4);
        chk({led_green, led_red}, 2'h2);
        @(posedge ref_clk);
        safety_in_a <= 1'b0;
        settle(4);
        chk({safety_out_a, led_red, led_yellow}, 3'h1);
        @(posedge ref_clk);
        {safety_in_a, safety_in_b, guard_closed, bolt_engaged} <= 4'h8;
        settle(4);
        chk({safety_out_b, led_red, led_yellow}, 3'h0);
    endtask

    task automatic s_lock_polarity;
        for (int p = 0; p < 2; p++) begin
            @(posedge ref_clk);
            base();
            power_to_lock_variant <= p[0];
            pwr_cycle();
            for (int w = 0; w < 2; w++) begin
                @(posedge ref_clk);
                want_lock <= w[0];
                settle(4);
                chk(solenoid_lock, w);
            end
        end
        @(posedge ref_clk);
        selector_pos_one <= 1'b0;
        settle(4);
        chk(solenoid_lock, 0);
        @(posedge ref_clk);
        selector_pos_two <= 1'b1;
        settle(4);
        chk(solenoid_lock, 1);
    endtask

    task automatic s_outputs;
        for (int d = 0; d < 2; d++) begin
            @(posedge ref_clk);
            base();
            door_monitor_variant <= d[0];
            want_lock <= 1'b1;
            pwr_cycle();
            settle(4);
            chk({safety_out_a, safety_out_b, guard_released}, 7);
            @(posedge ref_clk);
            bolt_engaged <= 1'b0;
            settle(4);
            chk({safety_out_a, safety_out_b}, {d[0], d[0]});
            @(posedge ref_clk);
            bolt_engaged <= 1'b1;
            settle(4);
            chk({safety_out_a, safety_out_b}, 3);
            @(posedge ref_clk);
            guard_closed <= 1'b0;
            settle(4);
            chk({safety_out_a, safety_out_b, guard_released}, 0);
        end
    endtask

    task automatic s_teach;
        logic [3:0] tbl [5] = '{4'h5, 4'h9, 4'ha, 4'h7, 4'h0};
        for (int i = 0; i < 5; i++) begin
            @(posedge ref_clk);
            base();
            {one_time_teach_variant, repeat_teach_variant} <= tbl[i][3:2];
            {nv_code_taught, actuator_new, actuator_present} <= {tbl[i][1], 2'h2};
            pwr_cycle();
            settle(4);
            chk(led_red, tbl[i][0]);
            if (tbl[i][0]) begin
                chk({led_green, safety_out_a}, 0);
            end
        end
    endtask

    task automatic s_confirm;
        int c, o, d;
        @(posedge ref_clk);
        base();
        {nv_pending, actuator_new} <= 2'h3;
        pwr_cycle();
        watch(70, c, o, d);
        chk(c, 1);
        chk(o + d, 0);
        chk(led_green, 0);
        watch(30, c, o, d);
        chk(d, 1);
        chk(o != 0, 1);
        chk(led_green, 1);
        @(posedge ref_clk);
        base();
        nv_pending <= 1'b1;
        pwr_cycle();
        watch(50, c, o, d);
        chk(c, 0);
    endtask

    task automatic s_inhibit;
        int c, o, d;
        @(posedge ref_clk);
        base();
        nv_inhibit <= 1'b1;
        pwr_cycle();
        watch(60, c, o, d);
        @(posedge ref_clk);
        pwr_cycle();
        watch(70, c, o, d);
        chk(o + d, 0);
        watch(30, c, o, d);
        chk(d, 1);
    endtask

    // Teach-in left to run out: power-off request, then the fault code.
    task automatic s_abort;
        int p = 0, r = 0, hi = 0;
        logic last = 1'b0;
        @(posedge ref_clk);
        base();
        {actuator_new, actuator_present} <= 2'h2;
        pwr_cycle();
        repeat (100) begin
            @(negedge ref_clk);
            p += (nv_set_pending === 1'b1);
        end
        chk(p, 1);
        chk({led_green, led_yellow, led_red}, 3'h4);
        repeat (26000) begin
            @(negedge ref_clk);
            r += (led_red === 1'b1 && last !== 1'b1);
            hi += (led_red === 1'b1);
            last = led_red;
        end
        chk(r, FAULT_FLASHES);
        chk(hi, FAULT_FLASHES * BLINK_1HZ_MS * TICK);
    endtask

    initial begin
        s_chain();
        s_lock_polarity();
        s_outputs();
        s_teach();
        s_confirm();
        s_inhibit();
        s_abort();
        report_and_stop();
    end
endmodule
